// ===== verilog/pmc_pkg.sv
/*
 * pmc_pkg: register map, field positions, reset values and timing
 * constants for the power mode and clock control block.
 * assumes: a 32-bit apb bus, one clock at 10 mhz.
 */
package pmc_pkg;
    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [11:0] PMC_OFS_POWER_CONTROL = 12'h000;
    localparam logic [11:0] PMC_OFS_POWER_MODE = 12'h004;
    localparam logic [11:0] PMC_OFS_EXT_IRQ_FLAG = 12'h008;
    localparam logic [11:0] PMC_OFS_STATUS = 12'h00C;
    // ************************************************************
    // field positions
    // ************************************************************
    localparam int PMC_BIT_IDLE = 0;
    localparam int PMC_BIT_PDOWN = 1;
    localparam int PMC_BIT_SWB = 5;
    localparam int PMC_BIT_CD_LO = 6;
    localparam int PMC_BIT_CD_HI = 7;
    localparam int PMC_BIT_CRYSTAL_AMP_OFF = 3;
    localparam int PMC_BIT_RC_WAKE = 1;
    localparam int PMC_BIT_RC_ACT = 2;
    localparam int PMC_BIT_OSC_SEL = 3;
    localparam int PMC_BIT_XT_READY = 4;
    // ************************************************************
    // divider codes and reset values
    // ************************************************************
    localparam logic [1:0] PMC_CD_RSVD = 2'h0;
    localparam logic [1:0] PMC_CD_DIV4 = 2'h1;
    localparam logic [1:0] PMC_CD_DIV64 = 2'h2;
    localparam logic [1:0] PMC_CD_DIV1024 = 2'h3;
    localparam logic [10:0] PMC_DIV4_CNT = 11'h004;
    localparam logic [10:0] PMC_DIV64_CNT = 11'h040;
    localparam logic [10:0] PMC_DIV1024_CNT = 11'h400;
    localparam logic [10:0] PMC_DIV_ONE = 11'h001;
    localparam logic [31:0] PMC_RD_ZERO = 32'h0000_0000;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int PMC_CLK_MHZ = 10;
    localparam int PMC_RST_MIN_CLK = 8;          // clock periods
    localparam int PMC_WDT_RST_CLK = 512;        // clock periods
    localparam int PMC_XT_WARM_US = 100;         // warm-up time, us
    localparam int PMC_XT_WARM_CYC = PMC_XT_WARM_US * PMC_CLK_MHZ;
    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {
        PMC_RUN,
        PMC_IDLE,
        PMC_PDOWN
    } pmc_mode_e;
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pmc_apb_req_s;
    typedef struct packed {
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } pmc_apb_rsp_s;
    typedef struct packed {
        logic serial_rx_en;
        logic serial_rx_fall;
        logic serial_tx_write;
        logic serial_busy;
        logic ext_irq_ack;
        logic irq_pending;
        logic wdt_timeout;
        logic [1:0] ext_irq_low;
        logic [1:0] ext_irq_level_mode;
        logic [1:0] ext_irq_enable;
        logic global_irq_enable;
    } pmc_evt_s;
    typedef struct packed {
        logic cpu_clk_en;
        logic periph_clk_en;
        logic osc_run;
        logic crystal_amp_on;
        logic rc_osc_on;
        logic use_rc;
        logic address_latch_strobe;
        logic program_store_strobe;
        logic port0_float;
        logic port2_addr;
        logic port_hold;
        logic core_reset;
    } pmc_ctl_s;
    typedef struct packed {
        pmc_mode_e mode;
        logic [1:0] cd;
        logic [1:0] cd_pend;
        logic cd_pend_v;
        logic switchback_enable;
        logic osc_sel;
        logic osc_pend;
        logic osc_pend_v;
        logic rc_act;
        logic crystal_amp_off;
        logic rc_wake;
        logic xt_ready;
        logic [15:0] warm_cnt;
        logic [10:0] div_cnt;
        logic [3:0] rst_cnt;
        logic [9:0] wdt_cnt;
        logic wdt_arm;
        logic wdt_reset;
        logic wake_rc;
        logic [31:0] prdata;
        logic pready;
    } pmc_state_s;
endpackage

// ===== verilog/pmc_power_mode_clock_control.sv
/*
 * pmc_power_mode_clock_control: idle, power-down, economy divider,
 * oscillator select and switchback, with an apb register slave.
 * assumes: the core decodes its own instruction stream and reports
 * serial, interrupt and watchdog events as single-cycle pulses; pins
 * are synchronous to clk_in.
 */
// Operation
// - idle bit write enters idle
// - idle stops cpu clock, peripherals keep running
// - idle strobes high, ports hold, p2 address
// - enabled interrupt wakes idle, clears idle bit
// - reset exit restarts core from zero
// - watchdog runs idle; reset 512 after timeout
// - two-bit code picks 4, 64, 1024
// - idle peripherals at div4, economy same rate
// - divider change waits one instruction cycle
// - source select delayed, read-only active flag
// - ready flag set; crystal select refused unready
// - switchback forces div4 on serial/irq
// - rx start edge or tx write triggers
// - divider writes ignored during serial activity while switchback is enabled
// - any reset forces divide-by-four
// - power-down stops clocks, strobes low
// - external reset exits power-down
// - level low enabled irq wakes power-down
// - rc wake then auto switch to crystal
`timescale 1ns/100ps
module pmc_power_mode_clock_control
    import pmc_pkg::*;
#(
    parameter int XT_WARM_CYC = PMC_XT_WARM_CYC,
    parameter int RST_MIN_CLK = PMC_RST_MIN_CLK
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // apb slave
    input wire pmc_apb_req_s apb_in,
    output pmc_apb_rsp_s apb_out,
    // pins and core events
    input wire logic ext_reset_in,
    input wire logic ext_prog_mem_in,
    input wire pmc_evt_s evt_in,
    // clock and pin control
    output pmc_ctl_s ctl_out,
    output logic [1:0] clk_div_sel_out
);
    // ************************************************************
    // helpers
    // ************************************************************
    // clocks per machine cycle for a divider code
    function automatic logic [10:0] div_len(input logic [1:0] code);
        case (code)
            PMC_CD_DIV64: div_len = PMC_DIV64_CNT;
            PMC_CD_DIV1024: div_len = PMC_DIV1024_CNT;
            default: div_len = PMC_DIV4_CNT;
        endcase
    endfunction

    pmc_state_s s_q; // whole state
    pmc_state_s s_d; // next state
    logic acc; // apb access phase
    logic wr; // apb write access
    logic mc_tick; // end of machine cycle at current rate
    logic div4_tick; // end of machine cycle at div4
    logic sw_back; // switchback trigger
    logic ext_rst_valid; // reset held long enough
    logic pd_wake_irq; // level irq wake from power-down
    logic any_reset; // internal reset request
    logic [3:0] rst_min; // reset hold count
    logic [15:0] warm_len; // crystal warm-up count

    assign rst_min = 4'(RST_MIN_CLK);
    assign warm_len = 16'(XT_WARM_CYC);
    assign acc = apb_in.psel && apb_in.penable;
    assign wr = acc && apb_in.pwrite;
    // at or past the end: a faster rate ticks at once
    assign mc_tick = (s_q.div_cnt >= div_len(s_q.cd) - PMC_DIV_ONE);
    assign div4_tick = (s_q.div_cnt[1:0] == 2'h3);
    // serial and irq activity only while enabled
    assign sw_back = s_q.switchback_enable && ((evt_in.serial_rx_en
        && evt_in.serial_rx_fall) || evt_in.serial_tx_write
        || evt_in.ext_irq_ack);
    // reset counted in clocks at pin
    assign ext_rst_valid = ext_reset_in
        && (s_q.rst_cnt >= rst_min - 4'h1);
    assign pd_wake_irq = evt_in.global_irq_enable
        && |(evt_in.ext_irq_low & evt_in.ext_irq_level_mode
        & evt_in.ext_irq_enable);
    assign any_reset = ext_rst_valid || s_q.wdt_reset;

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        s_d = s_q;
        s_d.pready = 1'b0;
        s_d.wdt_reset = 1'b0;
        // machine cycle divider, frozen in power-down
        if (s_q.mode != PMC_PDOWN) begin
            s_d.div_cnt = mc_tick ? 11'h000 : s_q.div_cnt + PMC_DIV_ONE;
        end
        // reset pin hold counter
        if (ext_reset_in) begin
            if (s_q.rst_cnt != 4'hF) begin
                s_d.rst_cnt = s_q.rst_cnt + 4'h1;
            end
        end else begin
            s_d.rst_cnt = 4'h0;
        end
        // delayed divider change, one instruction cycle
        if (s_q.cd_pend_v && mc_tick) begin
            s_d.cd = s_q.cd_pend;
            s_d.cd_pend_v = 1'b0;
        end
        // delayed oscillator change
        if (s_q.osc_pend_v && mc_tick) begin
            s_d.rc_act = !s_q.osc_pend;
            s_d.osc_pend_v = 1'b0;
        end
        // crystal warm-up, restarts when amplifier is off
        if (s_q.crystal_amp_off || s_q.mode == PMC_PDOWN) begin
            s_d.warm_cnt = 16'h0000;
            s_d.xt_ready = 1'b0;
        end else if (s_q.warm_cnt >= warm_len) begin
            s_d.xt_ready = 1'b1;
        end else begin
            s_d.warm_cnt = s_q.warm_cnt + 16'h0001;
        end
        // rc wake: go to crystal once stable
        if (s_q.wake_rc && s_q.xt_ready) begin
            s_d.wake_rc = 1'b0;
            s_d.rc_act = 1'b0;
        end
        // watchdog reset 512 clocks after an unserviced timeout
        if (s_q.mode != PMC_PDOWN) begin
            if (evt_in.wdt_timeout) begin
                s_d.wdt_arm = 1'b1;
                s_d.wdt_cnt = 10'h000;
            end else if (s_q.wdt_arm) begin
                s_d.wdt_cnt = s_q.wdt_cnt + 10'h001;
                if (s_q.wdt_cnt == 10'(PMC_WDT_RST_CLK - 1)) begin
                    s_d.wdt_reset = 1'b1;
                    s_d.wdt_arm = 1'b0;
                end
            end
        end
        // mode changes
        case (s_q.mode)
            PMC_IDLE: begin
                // irq or watchdog timeout wakes idle
                if (evt_in.irq_pending || evt_in.wdt_timeout) begin
                    s_d.mode = PMC_RUN;
                end
            end
            PMC_PDOWN: begin
                if (pd_wake_irq) begin
                    s_d.mode = PMC_RUN;
                    if (s_q.rc_wake) begin
                        s_d.rc_act = 1'b1;
                        s_d.wake_rc = 1'b1;
                    end
                end
            end
            default: begin
            end
        endcase
        // register writes and reads
        s_d.prdata = PMC_RD_ZERO;
        if (acc) begin
            // one wait state; a write lands on the completing edge
            s_d.pready = !s_q.pready;
            if (wr && s_q.pready) begin
                case (apb_in.paddr)
                    PMC_OFS_POWER_CONTROL: begin
                        // write is last instruction before mode
                        if (apb_in.pwdata[PMC_BIT_PDOWN]) begin
                            s_d.mode = PMC_PDOWN;
                        end else if (apb_in.pwdata[PMC_BIT_IDLE]) begin
                            s_d.mode = PMC_IDLE;
                        end
                    end
                    PMC_OFS_POWER_MODE: begin
                        s_d.switchback_enable = apb_in.pwdata[PMC_BIT_SWB];
                        // ignored when reserved, or when serial busy with switchback enabled
                        if (!(s_q.switchback_enable && evt_in.serial_busy)
                            && apb_in.pwdata[PMC_BIT_CD_HI:PMC_BIT_CD_LO]
                            != PMC_CD_RSVD) begin
                            s_d.cd_pend =
                                apb_in.pwdata[PMC_BIT_CD_HI:PMC_BIT_CD_LO];
                            s_d.cd_pend_v = 1'b1;
                        end
                        s_d.crystal_amp_off = apb_in.pwdata[PMC_BIT_CRYSTAL_AMP_OFF];
                    end
                    PMC_OFS_EXT_IRQ_FLAG: begin
                        s_d.rc_wake = apb_in.pwdata[PMC_BIT_RC_WAKE];
                        // crystal select refused while not ready
                        if (!apb_in.pwdata[PMC_BIT_OSC_SEL]
                            || s_q.xt_ready) begin
                            s_d.osc_sel = apb_in.pwdata[PMC_BIT_OSC_SEL];
                            s_d.osc_pend = apb_in.pwdata[PMC_BIT_OSC_SEL];
                            s_d.osc_pend_v = 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (!wr && !s_q.pready) begin
                case (apb_in.paddr)
                    PMC_OFS_POWER_CONTROL: begin
                        s_d.prdata[PMC_BIT_IDLE] = (s_q.mode == PMC_IDLE);
                        s_d.prdata[PMC_BIT_PDOWN] = (s_q.mode == PMC_PDOWN);
                    end
                    PMC_OFS_POWER_MODE: begin
                        s_d.prdata[PMC_BIT_CD_HI:PMC_BIT_CD_LO] = s_q.cd;
                        s_d.prdata[PMC_BIT_SWB] = s_q.switchback_enable;
                        s_d.prdata[PMC_BIT_CRYSTAL_AMP_OFF] = s_q.crystal_amp_off;
                    end
                    PMC_OFS_EXT_IRQ_FLAG: begin
                        s_d.prdata[PMC_BIT_OSC_SEL] = s_q.osc_sel;
                        s_d.prdata[PMC_BIT_RC_ACT] = s_q.rc_act;
                        s_d.prdata[PMC_BIT_RC_WAKE] = s_q.rc_wake;
                    end
                    PMC_OFS_STATUS: begin
                        s_d.prdata[PMC_BIT_XT_READY] = s_q.xt_ready;
                    end
                    default: begin
                    end
                endcase
            end
        end
        // switchback beats any pending slow selection
        if (sw_back) begin
            s_d.cd = PMC_CD_DIV4;
            s_d.cd_pend_v = 1'b0;
        end
        // any reset restores run at div4
        if (any_reset) begin
            s_d.mode = PMC_RUN;
            s_d.cd = PMC_CD_DIV4;
            s_d.cd_pend_v = 1'b0;
            s_d.switchback_enable = 1'b0;
            s_d.div_cnt = 11'h000;
        end
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            s_q <= '0;
            s_q.mode <= PMC_RUN;
            s_q.cd <= PMC_CD_DIV4;
            s_q.osc_sel <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    always_comb begin
        ctl_out = '0;
        // cpu halted in idle and power-down
        ctl_out.cpu_clk_en = (s_q.mode == PMC_RUN) && mc_tick;
        // peripherals at div4 in idle, economy rate when running
        case (s_q.mode)
            PMC_IDLE: ctl_out.periph_clk_en = div4_tick;
            PMC_RUN: ctl_out.periph_clk_en = mc_tick;
            default: ctl_out.periph_clk_en = 1'b0;
        endcase
        ctl_out.osc_run = (s_q.mode != PMC_PDOWN);
        ctl_out.crystal_amp_on = !s_q.crystal_amp_off && (s_q.mode != PMC_PDOWN);
        ctl_out.rc_osc_on = s_q.rc_act && (s_q.mode != PMC_PDOWN);
        ctl_out.use_rc = s_q.rc_act;
        // strobes: high in idle, low in power-down
        ctl_out.address_latch_strobe = (s_q.mode == PMC_IDLE);
        ctl_out.program_store_strobe = (s_q.mode == PMC_IDLE);
        ctl_out.port_hold = (s_q.mode != PMC_RUN);
        ctl_out.port0_float = (s_q.mode != PMC_RUN) && ext_prog_mem_in;
        ctl_out.port2_addr = (s_q.mode == PMC_IDLE) && ext_prog_mem_in;
        ctl_out.core_reset = any_reset;
        clk_div_sel_out = s_q.cd;
        apb_out.pready = s_q.pready;
        apb_out.pslverr = 1'b0;
        apb_out.prdata = s_q.prdata;
    end
endmodule // pmc_power_mode_clock_control

// ===== verif/pmc_power_mode_clock_control_checker.sv
/*
 * checker: timing relations at the ports of the power mode block.
 * assumes: one clock, sync active-low reset, bound to the top module.
 */
`timescale 1ns/100ps
module pmc_power_mode_clock_control_checker
    import pmc_pkg::*;
#(
    parameter int XT_WARM_CYC = PMC_XT_WARM_CYC,
    parameter int RST_MIN_CLK = PMC_RST_MIN_CLK
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // apb
    input wire pmc_apb_req_s apb_in,
    input wire pmc_apb_rsp_s apb_out,
    // pins and events
    input wire logic ext_reset_in,
    input wire logic ext_prog_mem_in,
    input wire pmc_evt_s evt_in,
    // control outputs
    input wire pmc_ctl_s ctl_out,
    input wire logic [1:0] clk_div_sel_out
);
    // ************************************************************
    // helper: edges the reset pin has stayed high
    // ************************************************************
    logic [3:0] hi_q; // saturating run length
    logic [3:0] hi_d;
    // next run length
    always_comb begin
        hi_d = hi_q;
        if (!ext_reset_in)
            hi_d = 4'h0;
        else if (hi_q != 4'hF)
            hi_d = hi_q + 4'h1;
    end
    // register the run length
    always_ff @(posedge clk_in) begin
        if (!rst_n_in)
            hi_q <= 4'h0;
        else
            hi_q <= hi_d;
    end
    // ************************************************************
    // properties
    // ************************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    property p_rdy_ans;
        apb_in.psel && apb_in.penable && !apb_out.pready |=> apb_out.pready;
    endproperty
    a_rdy_ans: assert property (p_rdy_ans) else $error("no answer");
    property p_rdy_one;
        apb_out.pready |=> !apb_out.pready && !apb_out.pslverr;
    endproperty
    a_rdy_one: assert property (p_rdy_one) else $error("ready too long");
    property p_idle_frz;
        ctl_out.address_latch_strobe |-> !ctl_out.cpu_clk_en &&
            ctl_out.port_hold && ctl_out.program_store_strobe;
    endproperty
    a_idle_frz: assert property (p_idle_frz)
        else $error("idle not frozen");
    property p_idle_ext;
        ctl_out.address_latch_strobe && ext_prog_mem_in |->
            ctl_out.port0_float && ctl_out.port2_addr;
    endproperty
    a_idle_ext: assert property (p_idle_ext)
        else $error("idle port state");
    property p_idle_per;
        (ctl_out.address_latch_strobe && ctl_out.periph_clk_en ##4
            ctl_out.address_latch_strobe) |-> ctl_out.periph_clk_en;
    endproperty
    a_idle_per: assert property (p_idle_per)
        else $error("idle peripheral rate");
    property p_pd_stop;
        !ctl_out.osc_run |-> !ctl_out.cpu_clk_en && !ctl_out.periph_clk_en
            && !ctl_out.address_latch_strobe && !ctl_out.program_store_strobe;
    endproperty
    a_pd_stop: assert property (p_pd_stop)
        else $error("power-down clocks");
    property p_pd_p0;
        !ctl_out.osc_run && ext_prog_mem_in |-> ctl_out.port0_float;
    endproperty
    a_pd_p0: assert property (p_pd_p0)
        else $error("power-down port0");
    property p_cd_rsvd;
        clk_div_sel_out != PMC_CD_RSVD;
    endproperty
    a_cd_rsvd: assert property (p_cd_rsvd)
        else $error("reserved divider");
    property p_rst_div;
        ctl_out.core_reset |=> clk_div_sel_out == PMC_CD_DIV4;
    endproperty
    a_rst_div: assert property (p_rst_div)
        else $error("reset divider");
    property p_rst_min;
        ctl_out.core_reset && ext_reset_in |-> hi_q >= RST_MIN_CLK - 1;
    endproperty
    a_rst_min: assert property (p_rst_min)
        else $error("reset too early");
    property p_rst_go;
        ext_reset_in [*8] |-> ##[0:3] ctl_out.core_reset;
    endproperty
    a_rst_go: assert property (p_rst_go)
        else $error("reset not taken");
    c_idle: cover property (ctl_out.address_latch_strobe);
    c_pdown: cover property (!ctl_out.osc_run);
    c_reset: cover property (ctl_out.core_reset);
endmodule // pmc_power_mode_clock_control_checker
bind pmc_power_mode_clock_control pmc_power_mode_clock_control_checker #(
    .XT_WARM_CYC(XT_WARM_CYC), .RST_MIN_CLK(RST_MIN_CLK)
) u_pmc_power_mode_clock_control_checker (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .apb_in(apb_in),
    .apb_out(apb_out), .ext_reset_in(ext_reset_in),
    .ext_prog_mem_in(ext_prog_mem_in), .evt_in(evt_in),
    .ctl_out(ctl_out), .clk_div_sel_out(clk_div_sel_out)
);

// ===== verif/pmc_power_mode_clock_control_bench.sv
/*
 * bench: apb sequences with expected values for the power mode block.
 * assumes: the checker is bound; warm-up shortened to 10 cycles.
 */
`timescale 1ns/100ps
`define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp %0h got %0h", nm, e, a); end end
module pmc_power_mode_clock_control_bench
    import pmc_pkg::*;
;
    // ************************************************************
    // signals
    // ************************************************************
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic ext_reset_in = 1'b0;
    logic ext_prog_mem_in = 1'b1; // external program memory
    pmc_apb_req_s apb_in = '0;
    pmc_apb_rsp_s apb_out;
    pmc_evt_s evt_in = '0;
    pmc_ctl_s ctl_out;
    logic [1:0] clk_div_sel_out;
    logic [31:0] rd; // last read data
    int n_fail = 0;
    int n_tests = 0;
    int n_cyc = 0;
    int n_rst = 0; // cycles with core reset seen
    int cc;
    int pc;
    int k;
    always #50 clk_in = ~clk_in;
    pmc_power_mode_clock_control #(
        .XT_WARM_CYC(10), .RST_MIN_CLK(PMC_RST_MIN_CLK)
    ) u_pmc_power_mode_clock_control (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .apb_in(apb_in),
        .apb_out(apb_out), .ext_reset_in(ext_reset_in),
        .ext_prog_mem_in(ext_prog_mem_in), .evt_in(evt_in),
        .ctl_out(ctl_out), .clk_div_sel_out(clk_div_sel_out)
    );
    // ************************************************************
    // tasks
    // ************************************************************
    task automatic test_done;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // one apb transfer, held until pready is sampled
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_in);
        apb_in <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a,
                    pwdata: d};
        @(posedge clk_in);
        apb_in.penable <= 1'b1;
        do @(posedge clk_in); while (apb_out.pready !== 1'b1);
        rd = apb_out.prdata;
        apb_in <= '0;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
    endtask
    // count cpu and peripheral enables over n cycles
    task automatic cnt(input int n);
        cc = 0;
        pc = 0;
        repeat (n) begin
            @(posedge clk_in);
            cc += ctl_out.cpu_clk_en;
            pc += ctl_out.periph_clk_en;
        end
    endtask
    // cycle counter, reset monitor and hang limit
    always @(posedge clk_in) begin
        n_cyc++;
        if (ctl_out.core_reset === 1'b1)
            n_rst++;
        if (n_cyc == 20000) begin
            n_fail++;
            test_done();
        end
    end
    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        cyc(6);
        rst_n_in <= 1'b1;
        apb(0, PMC_OFS_POWER_MODE, 0);
        `CHK("pmr_rst", 32'h40, rd & 32'hE8)
        apb(0, PMC_OFS_EXT_IRQ_FLAG, 0);
        `CHK("ext_irq_flag_reg_rst", 32'h08, rd & 32'h0E)
        apb(1, 12'h010, 32'hFF);
        apb(0, 12'h010, 0);
        `CHK("unmapped", 32'h0, rd)
        // economy rates and the reserved code
        apb(1, PMC_OFS_POWER_MODE, 32'h80);
        cyc(8);
        `CHK("div64", PMC_CD_DIV64, clk_div_sel_out)
        cnt(640);
        `CHK("cpu64", 10, cc)
        `CHK("per64", 10, pc)
        apb(1, PMC_OFS_POWER_MODE, 32'h00);
        cyc(140);
        `CHK("rsvd", PMC_CD_DIV64, clk_div_sel_out)
        apb(1, PMC_OFS_POWER_MODE, 32'h40);
        cyc(140);
        apb(1, PMC_OFS_POWER_MODE, 32'hC0);
        cyc(8);
        cnt(4096);
        `CHK("cpu1024", 4, cc)
        `CHK("per1024", 4, pc)
        // switchback on tx write, rx start edge, irq acknowledge
        evt_in.serial_rx_en <= 1'b1;
        for (k = 0; k < 3; k++) begin
            apb(1, PMC_OFS_POWER_MODE, 32'hE0);
            cyc(8);
            `CHK("slow", PMC_CD_DIV1024, clk_div_sel_out)
            evt_in.serial_tx_write <= (k == 0);
            evt_in.serial_rx_fall <= (k == 1);
            evt_in.ext_irq_ack <= (k == 2);
            cyc(1);
            evt_in.serial_tx_write <= 1'b0;
            evt_in.serial_rx_fall <= 1'b0;
            evt_in.ext_irq_ack <= 1'b0;
            cyc(3);
            `CHK("swb", PMC_CD_DIV4, clk_div_sel_out)
        end
        evt_in.serial_busy <= 1'b1;
        apb(1, PMC_OFS_POWER_MODE, 32'hA0);
        cyc(8);
        `CHK("busy", PMC_CD_DIV4, clk_div_sel_out)
        evt_in.serial_busy <= 1'b0;
        apb(1, PMC_OFS_POWER_MODE, 32'h40);
        // idle entry and interrupt wake
        apb(1, PMC_OFS_POWER_CONTROL, 32'h1);
        cyc(4);
        cnt(40);
        `CHK("idle_cpu", 0, cc)
        `CHK("idle_per", 10, pc)
        `CHK("idle_p2", 1'b1, ctl_out.port2_addr)
        apb(0, PMC_OFS_POWER_CONTROL, 0);
        `CHK("idle_bit", 32'h1, rd & 32'h3)
        evt_in.irq_pending <= 1'b1;
        cyc(3);
        evt_in.irq_pending <= 1'b0;
        apb(0, PMC_OFS_POWER_CONTROL, 0);
        `CHK("irq_wake", 32'h0, rd & 32'h3)
        // watchdog wake, then its reset after 512 clocks
        apb(1, PMC_OFS_POWER_MODE, 32'h80);
        cyc(8);
        apb(1, PMC_OFS_POWER_CONTROL, 32'h1);
        cyc(4);
        evt_in.wdt_timeout <= 1'b1;
        cyc(1);
        evt_in.wdt_timeout <= 1'b0;
        k = n_rst;
        apb(0, PMC_OFS_POWER_CONTROL, 0);
        `CHK("wdt_wake", 32'h0, rd & 32'h3)
        cyc(490);
        `CHK("wdt_early", k, n_rst)
        cyc(30);
        `CHK("wdt_rst", 1'b1, n_rst > k)
        `CHK("wdt_div", PMC_CD_DIV4, clk_div_sel_out)
        // short reset pulse is not valid
        k = n_rst;
        ext_reset_in <= 1'b1;
        cyc(4);
        ext_reset_in <= 1'b0;
        cyc(4);
        `CHK("rst_short", k, n_rst)
        // power-down; watchdog cannot end it, reset pin can
        apb(1, PMC_OFS_POWER_MODE, 32'h80);
        cyc(8);
        apb(1, PMC_OFS_POWER_CONTROL, 32'h2);
        cyc(4);
        cnt(40);
        `CHK("pd_clk", 0, cc + pc)
        `CHK("pd_p0", 1'b1, ctl_out.port0_float)
        evt_in.wdt_timeout <= 1'b1;
        cyc(1);
        evt_in.wdt_timeout <= 1'b0;
        cyc(8);
        `CHK("pd_wdt", 1'b0, ctl_out.osc_run)
        ext_reset_in <= 1'b1;
        cyc(12);
        ext_reset_in <= 1'b0;
        cyc(4);
        `CHK("pd_rst", 1'b1, ctl_out.osc_run)
        `CHK("pd_div", PMC_CD_DIV4, clk_div_sel_out)
        // oscillator select and crystal ready
        cyc(20);
        apb(0, PMC_OFS_STATUS, 0);
        `CHK("xt_up", 32'h10, rd & 32'h10)
        apb(1, PMC_OFS_EXT_IRQ_FLAG, 32'h0);
        cyc(8);
        `CHK("to_rc", 1'b1, ctl_out.use_rc)
        `CHK("rc_on", 1'b1, ctl_out.rc_osc_on)
        apb(0, PMC_OFS_EXT_IRQ_FLAG, 0);
        `CHK("rc_flag", 32'h4, rd & 32'hC)
        apb(1, PMC_OFS_POWER_MODE, 32'h48);
        cyc(4);
        `CHK("amp_off", 1'b0, ctl_out.crystal_amp_on)
        apb(0, PMC_OFS_STATUS, 0);
        `CHK("xt_down", 32'h0, rd & 32'h10)
        apb(1, PMC_OFS_EXT_IRQ_FLAG, 32'h8);
        cyc(8);
        `CHK("xt_refuse", 1'b1, ctl_out.use_rc)
        apb(1, PMC_OFS_POWER_MODE, 32'h40);
        cyc(20);
        apb(1, PMC_OFS_EXT_IRQ_FLAG, 32'hA);
        cyc(8);
        `CHK("to_xt", 1'b0, ctl_out.use_rc)
        // level interrupt wake from power-down on the rc oscillator
        apb(1, PMC_OFS_POWER_CONTROL, 32'h2);
        cyc(4);
        evt_in.global_irq_enable <= 1'b1;
        evt_in.ext_irq_enable <= 2'h1;
        evt_in.ext_irq_level_mode <= 2'h1;
        evt_in.ext_irq_low <= 2'h1;
        cyc(3);
        `CHK("lvl_wake", 1'b1, ctl_out.osc_run)
        `CHK("rc_wake", 1'b1, ctl_out.use_rc)
        evt_in.ext_irq_low <= 2'h0;
        cyc(30);
        `CHK("auto_xt", 1'b0, ctl_out.use_rc)
        apb(0, PMC_OFS_POWER_CONTROL, 0);
        `CHK("pd_bit", 32'h0, rd & 32'h3)
        test_done();
    end
endmodule // pmc_power_mode_clock_control_bench
